// *** common/cipher_key_pkg.sv ***
// Function
// RULE_01: Configuration page bit 30 shows whether the page has been programmed.
// RULE_02: Four 2-bit key-type fields at bits 27-20, one per OTP page pair.
// RULE_03: Key type 00 DES/2DES, 01 3DES, 10 AES-128, 11 AES-192/256.
// RULE_04: Session-key enable at bit 19 makes any stored-key selection an error.
// RULE_05: With source lock, the highest set locked-field bit gives the source code.
// RULE_06: Bit 10 picks locked field or software source; clear ignores locked field.
// RULE_07: Write-lock bits 9-1 forbid programming of pages 0 through 8.
// RULE_08: Software key disabled with source 0000 sets key failure, blocks starts.
// RULE_09: Software leaves reserved bit 31 of the configuration page unchanged.
// RULE_10: Single DES: 0000 software bits 63:0, 0001-0111 stored keys 1-7.
// RULE_11: 2-key 3DES: passes one and three use first key, pass two second.
// RULE_12: 3-key 3DES: three consecutive slices; source 0001 keys 1-3, 0010 keys 4-6.
// RULE_13: AES-128 sources 0001-0100; AES-192/256 sources 0001-0010; mode 11 error.
// RULE_14: Key failure is set on invalid selections and clears once valid.
// RULE_15: Key mode codes per cipher; DES 10 and AES 11 are reserved.
// RULE_16: No OTP program operation starts while key failure is set.
// RULE_17: Programming writes page 0 or key pages 1-8 from the third text buffer.
// RULE_18: Program-once bits only go from 0 to 1; image reloads after reset.
package cipher_key_pkg;
    localparam int          NUM_KEY_PAGES     = 8;
    localparam int          NUM_PAIRS         = 4;
    localparam int          CFG_W             = 32;
    localparam int          CFG_RSVD_BIT      = 31;
    localparam int          CFG_PROG_FLAG_BIT = 30;
    localparam int          CFG_TYPE_LSB      = 20;
    localparam int          CFG_SESS_BIT      = 19;
    localparam int          CFG_LOCKSRC_LSB   = 11;
    localparam int          CFG_LOCKSRC_W     = 8;
    localparam int          CFG_SRCLOCK_BIT   = 10;
    localparam int          CFG_PAGE_WRITE_LOCK_LSB    = 1;
    localparam int          CFG_SWDIS_BIT     = 0;
    localparam logic [31:0] CFG_RESET         = 32'h0000_0000;
    localparam logic [31:0] CFG_READ_MASK     = 32'hcfff_ffff;
    localparam logic [31:0] CFG_PROG_MASK     = 32'h4fff_ffff;
    localparam logic [1:0]  DES_SINGLE        = 2'h0;
    localparam logic [1:0]  DES_TWO_KEY       = 2'h1;
    localparam logic [1:0]  DES_RSVD          = 2'h2;
    localparam logic [1:0]  DES_THREE_KEY     = 2'h3;
    localparam logic [1:0]  AES_128           = 2'h0;
    localparam logic [1:0]  AES_192           = 2'h1;
    localparam logic [1:0]  AES_256           = 2'h2;
    localparam logic [1:0]  AES_RSVD          = 2'h3;
    localparam logic [1:0]  TYPE_DES          = 2'h0;
    localparam logic [1:0]  TYPE_3DES         = 2'h1;
    localparam logic [1:0]  TYPE_AES128       = 2'h2;
    localparam logic [1:0]  TYPE_AES_WIDE     = 2'h3;
    localparam logic [3:0]  SRC_SOFTWARE      = 4'h0;
    localparam logic [3:0]  SRC_LOCK_TOP      = 4'hf;
    localparam logic [3:0]  LAST_PAGE         = 4'h8;
    localparam logic [3:0]  CFG_PAGE_INDEX    = 4'h0;
endpackage

// *** rtl/cipher_key_source_config.sv ***
module cipher_key_source_config #(
    parameter int PAGE_W = 64
) (
    // Clock and reset
    input  wire logic                   REF_CLK_I,
    input  wire logic                   SRST_I,
    // Cipher selection from software
    input  wire logic                   CIPHER_SELECT_I,
    input  wire logic [1:0]             KEY_MODE_FIELD_I,
    input  wire logic [3:0]             KEY_SOURCE_CODE_I,
    input  wire logic [4*PAGE_W-1:0]    SOFTWARE_KEY_REGISTER_I,
    input  wire logic                   CIPHER_START_I,
    // OTP array image read back after reset
    input  wire logic [31:0]            OTP_CFG_IMAGE_I,
    input  wire logic [8*PAGE_W-1:0]    OTP_KEY_IMAGE_I,
    // OTP programming
    input  wire logic                   OTP_PROGRAM_START_I,
    input  wire logic [3:0]             OTP_PAGE_SELECT_I,
    input  wire logic [PAGE_W-1:0]      THIRD_TEXT_BUFFER_I,
    // Key resolution results
    output logic                        KEY_FAILURE_FLAG_O,
    output logic                        CIPHER_GO_O,
    output logic [PAGE_W-1:0]           PASS1_KEY_O,
    output logic [PAGE_W-1:0]           PASS2_KEY_O,
    output logic [PAGE_W-1:0]           PASS3_KEY_O,
    output logic [4*PAGE_W-1:0]         AES_KEY_O,
    // Configuration page and programming status
    output logic [31:0]                 SECURE_KEY_CONFIG_PAGE_O,
    output logic                        PROGRAM_TEST_MIRROR_O,
    output logic                        PROGRAM_DONE_O,
    output logic                        PROGRAM_FAIL_O,
    output logic                        OTP_LOAD_BUSY_O
);
    localparam int KEY_W  = 4 * PAGE_W;
    localparam int FLAT_W = cipher_key_pkg::NUM_KEY_PAGES * PAGE_W;

    // The configuration page is programmed from the low 32 bits of a page.
    if (PAGE_W < 32 || PAGE_W % 8 != 0) begin : g_bad_width
        $error("PAGE_W must be a multiple of 8 and at least 32");
    end

    logic [31:0]        cfg_q;
    logic [PAGE_W-1:0]  key_pg_q [cipher_key_pkg::NUM_KEY_PAGES];
    logic               load_q;
    logic               key_fail_q;
    logic               go_q;
    logic               done_q;
    logic               pfail_q;
    logic [PAGE_W-1:0]  pass1_q;
    logic [PAGE_W-1:0]  pass2_q;
    logic [PAGE_W-1:0]  pass3_q;
    logic [KEY_W-1:0]   aes_q;

    // Configuration page fields.
    wire       sess_en  = cfg_q[cipher_key_pkg::CFG_SESS_BIT];
    wire       src_lock = cfg_q[cipher_key_pkg::CFG_SRCLOCK_BIT];
    wire       sw_dis   = cfg_q[cipher_key_pkg::CFG_SWDIS_BIT];
    wire [7:0] lock_fld = cfg_q[cipher_key_pkg::CFG_LOCKSRC_LSB +:
                                cipher_key_pkg::CFG_LOCKSRC_W];

    // Locked source is a priority encoder on the locked field.
    logic [3:0] lock_src;
    always_comb begin
        lock_src = cipher_key_pkg::SRC_SOFTWARE;
        for (int i = 0; i < 7; i++) begin
            if (lock_fld[i]) begin
                lock_src = 4'(i + 1); // RULE_05
            end
        end
        if (lock_fld[7]) begin
            lock_src = cipher_key_pkg::SRC_LOCK_TOP; // RULE_05
        end
    end

    wire [3:0] eff_src = src_lock ? lock_src : KEY_SOURCE_CODE_I; // RULE_06

    // Pages per key, highest legal source and the key type it demands.
    logic [2:0] n_pg;
    logic [3:0] max_src;
    logic [1:0] req_type;
    logic       mode_bad;
    always_comb begin
        n_pg     = 3'h0;
        max_src  = 4'h0;
        req_type = cipher_key_pkg::TYPE_DES;
        mode_bad = 1'b0;
        unique case ({CIPHER_SELECT_I, KEY_MODE_FIELD_I})
            {1'b0, cipher_key_pkg::DES_SINGLE}: begin
                n_pg    = 3'h1; // RULE_10
                max_src = 4'h7;
            end
            {1'b0, cipher_key_pkg::DES_TWO_KEY}: begin
                n_pg    = 3'h2; // RULE_11
                max_src = 4'h4;
            end
            {1'b0, cipher_key_pkg::DES_RSVD}: begin
                mode_bad = 1'b1; // RULE_15
            end
            {1'b0, cipher_key_pkg::DES_THREE_KEY}: begin
                n_pg     = 3'h3; // RULE_12
                max_src  = 4'h2;
                req_type = cipher_key_pkg::TYPE_3DES;
            end
            {1'b1, cipher_key_pkg::AES_128}: begin
                n_pg     = 3'h2; // RULE_13
                max_src  = 4'h4;
                req_type = cipher_key_pkg::TYPE_AES128;
            end
            {1'b1, cipher_key_pkg::AES_192}: begin
                n_pg     = 3'h3; // RULE_13
                max_src  = 4'h2;
                req_type = cipher_key_pkg::TYPE_AES_WIDE;
            end
            {1'b1, cipher_key_pkg::AES_256}: begin
                n_pg     = 3'h4; // RULE_13
                max_src  = 4'h2;
                req_type = cipher_key_pkg::TYPE_AES_WIDE;
            end
            {1'b1, cipher_key_pkg::AES_RSVD}: begin
                mode_bad = 1'b1; // RULE_13
            end
        endcase
    end

    // Stored keys occupy consecutive pages from the first page upward.
    wire        src_sw   = eff_src == cipher_key_pkg::SRC_SOFTWARE;
    wire        range_bad = eff_src > max_src; // RULE_14
    wire [5:0]  first_pg = 6'(eff_src - 4'h1) * 6'(n_pg);
    wire [5:0]  last_pg  = first_pg + 6'(n_pg) - 6'h1;

    // A stored key may span two pairs; every pair it touches is checked.
    logic [cipher_key_pkg::NUM_PAIRS-1:0] type_bad;
    logic [FLAT_W-1:0]                    otp_flat;
    for (genvar p = 0; p < cipher_key_pkg::NUM_PAIRS; p++) begin : g_pair
        wire [1:0] ktype = cfg_q[cipher_key_pkg::CFG_TYPE_LSB + 2*p +: 2];
        wire       used  = (last_pg >= 6'(2*p)) && (first_pg <= 6'(2*p+1));
        assign type_bad[p] = used && (ktype != req_type); // RULE_02 RULE_03
    end
    for (genvar k = 0; k < cipher_key_pkg::NUM_KEY_PAGES; k++) begin : g_flat
        assign otp_flat[k*PAGE_W +: PAGE_W] = key_pg_q[k];
    end

    wire key_err = mode_bad
                 | (src_sw && sw_dis) // RULE_08
                 | (!src_sw && (range_bad || sess_en // RULE_04
                                || (|type_bad)))
                 | load_q;

    // Software key or the stored slice, trimmed to the key length.
    wire [FLAT_W-1:0] otp_shift = otp_flat >> (int'(first_pg) * PAGE_W);
    wire [KEY_W-1:0]  key_mask  = {KEY_W{1'b1}}
                                  >> (KEY_W - int'(n_pg) * PAGE_W);
    wire [KEY_W-1:0]  key_word  = (src_sw ? SOFTWARE_KEY_REGISTER_I
                                          : otp_shift[KEY_W-1:0])
                                  & key_mask;
    wire is_des3 = !CIPHER_SELECT_I &&
                   KEY_MODE_FIELD_I == cipher_key_pkg::DES_THREE_KEY;
    wire is_des2 = !CIPHER_SELECT_I &&
                   KEY_MODE_FIELD_I == cipher_key_pkg::DES_TWO_KEY;
    wire [PAGE_W-1:0] p1_d = key_word[PAGE_W-1:0];
    wire [PAGE_W-1:0] p2_d = (is_des2 || is_des3)
                             ? key_word[PAGE_W +: PAGE_W] : p1_d; // RULE_11
    wire [PAGE_W-1:0] p3_d = is_des3
                             ? key_word[2*PAGE_W +: PAGE_W] : p1_d; // RULE_12

    // Key material is zeroed while the selection is invalid so that a
    // refused stored key never reaches the datapath.
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            key_fail_q <= 1'b1;
            go_q       <= 1'b0;
            pass1_q    <= '0;
            pass2_q    <= '0;
            pass3_q    <= '0;
            aes_q      <= '0;
        end else begin
            key_fail_q <= key_err; // RULE_14
            go_q       <= CIPHER_START_I && !key_fail_q; // RULE_08
            pass1_q    <= (key_err || CIPHER_SELECT_I) ? '0 : p1_d;
            pass2_q    <= (key_err || CIPHER_SELECT_I) ? '0 : p2_d;
            pass3_q    <= (key_err || CIPHER_SELECT_I) ? '0 : p3_d;
            aes_q      <= (key_err || !CIPHER_SELECT_I) ? '0 : key_word;
        end
    end

    // Programming: only the chosen page, only when unlocked and valid.
    wire pg_rsvd   = OTP_PAGE_SELECT_I > cipher_key_pkg::LAST_PAGE;
    wire pg_locked = !pg_rsvd &&
        cfg_q[cipher_key_pkg::CFG_PAGE_WRITE_LOCK_LSB + int'(OTP_PAGE_SELECT_I)];
    wire prog_ok   = OTP_PROGRAM_START_I && !load_q && !pg_rsvd
                     && !pg_locked && !key_fail_q; // RULE_07 RULE_16
    wire prog_cfg  = prog_ok &&
                     OTP_PAGE_SELECT_I == cipher_key_pkg::CFG_PAGE_INDEX;
    wire [31:0] cfg_d = cfg_q | (THIRD_TEXT_BUFFER_I[31:0]
                                 & cipher_key_pkg::CFG_PROG_MASK)
                        | (32'h1 << cipher_key_pkg::CFG_PROG_FLAG_BIT);

    // The array image is copied in on the first edge after reset release.
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            load_q  <= 1'b1;
            cfg_q   <= cipher_key_pkg::CFG_RESET;
            done_q  <= 1'b0;
            pfail_q <= 1'b0;
        end else begin
            load_q  <= 1'b0;
            done_q  <= prog_ok;
            pfail_q <= OTP_PROGRAM_START_I && !prog_ok;
            if (load_q) begin
                cfg_q <= OTP_CFG_IMAGE_I
                         & cipher_key_pkg::CFG_READ_MASK; // RULE_18
            end else if (prog_cfg) begin
                cfg_q <= cfg_d; // RULE_01 RULE_09 RULE_17 RULE_18
            end
        end
    end

    for (genvar k = 0; k < cipher_key_pkg::NUM_KEY_PAGES; k++) begin : g_page
        wire hit = prog_ok && OTP_PAGE_SELECT_I == 4'(k + 1);
        always_ff @(posedge REF_CLK_I) begin
            if (SRST_I) begin
                key_pg_q[k] <= '0;
            end else if (load_q) begin
                key_pg_q[k] <= OTP_KEY_IMAGE_I[k*PAGE_W +: PAGE_W];
            end else if (hit) begin
                key_pg_q[k] <= key_pg_q[k] | THIRD_TEXT_BUFFER_I; // RULE_17
            end
        end
    end

    assign KEY_FAILURE_FLAG_O       = key_fail_q;
    assign CIPHER_GO_O              = go_q;
    assign PASS1_KEY_O              = pass1_q;
    assign PASS2_KEY_O              = pass2_q;
    assign PASS3_KEY_O              = pass3_q;
    assign AES_KEY_O                = aes_q;
    assign SECURE_KEY_CONFIG_PAGE_O = cfg_q;
    assign PROGRAM_TEST_MIRROR_O    = cfg_q[cipher_key_pkg::CFG_PROG_FLAG_BIT];
    assign PROGRAM_DONE_O           = done_q;
    assign PROGRAM_FAIL_O           = pfail_q;
    assign OTP_LOAD_BUSY_O          = load_q;

    // Named slices keep each sampled-value call on a whole signal.
    wire [PAGE_W-1:0] sw_slice0 = SOFTWARE_KEY_REGISTER_I[PAGE_W-1:0];
    wire [PAGE_W-1:0] sw_slice2 = SOFTWARE_KEY_REGISTER_I[2*PAGE_W +: PAGE_W];

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);

    a_swdis_fail: assert property (!load_q && sw_dis && src_sw // RULE_08
        |=> key_fail_q) else $error("software key disable not flagged");
    a_go_blocked: assert property (CIPHER_START_I && key_fail_q // RULE_08
        |=> !go_q) else $error("start accepted with key failure");
    a_sess_fail: assert property (sess_en && !src_sw // RULE_04
        |=> key_fail_q) else $error("stored key used under session mode");
    a_lock_top: assert property (src_lock && lock_fld[7] // RULE_05
        |-> eff_src == 4'hf) else $error("locked field top bit not 1111");
    a_unlock_src: assert property (!src_lock // RULE_06
        |-> eff_src == KEY_SOURCE_CODE_I)
        else $error("locked field not ignored");
    a_wr_lock: assert property (OTP_PROGRAM_START_I && pg_locked // RULE_07
        |=> PROGRAM_FAIL_O && !PROGRAM_DONE_O)
        else $error("locked page accepted for programming");
    a_prog_refuse: assert property ( // RULE_16
        OTP_PROGRAM_START_I && key_fail_q |=> PROGRAM_FAIL_O)
        else $error("programming started under key failure");
    a_des_rsvd: assert property (!CIPHER_SELECT_I && // RULE_15
        KEY_MODE_FIELD_I == 2'h2 |=> key_fail_q ##0 PASS1_KEY_O == '0)
        else $error("reserved DES mode accepted");
    a_aes_rsvd: assert property (CIPHER_SELECT_I && // RULE_13
        KEY_MODE_FIELD_I == 2'h3 |=> key_fail_q && AES_KEY_O == '0)
        else $error("reserved AES mode accepted");
    a_des_sw: assert property ( // RULE_10
        !key_err && !CIPHER_SELECT_I && src_sw && KEY_MODE_FIELD_I == 2'h0
        |=> PASS1_KEY_O == $past(sw_slice0))
        else $error("single DES software key wrong");
    a_3des_sw: assert property (!key_err && is_des3 && src_sw // RULE_12
        |=> PASS3_KEY_O == $past(sw_slice2))
        else $error("third pass key wrong");
    a_key_zero: assert property (key_err // RULE_14
        |=> PASS1_KEY_O == '0 && PASS3_KEY_O == '0 && AES_KEY_O == '0)
        else $error("key material not cleared on key failure");
    a_2des_pass: assert property (!key_err && is_des2 // RULE_11
        |=> PASS3_KEY_O == PASS1_KEY_O && !key_fail_q)
        else $error("two-key passes mismatched");
    a_rsvd_src: assert property (eff_src == 4'hf // RULE_14
        |=> key_fail_q) else $error("reserved source not flagged");
    a_fail_clear: assert property (key_fail_q && !key_err // RULE_14
        |=> !key_fail_q) else $error("key failure did not clear");
    a_type_check: assert property (!CIPHER_SELECT_I && // RULE_03 RULE_02
        KEY_MODE_FIELD_I == 2'h0 && eff_src == 4'h1 &&
        cfg_q[21:20] != 2'h0 |=> key_fail_q)
        else $error("key type mismatch not flagged");
    a_po_sticky: assert property (!$past(load_q) && !load_q // RULE_18
        |-> ($past(cfg_q) & ~cfg_q) == '0)
        else $error("program-once bit cleared");
    a_prog_flag: assert property (prog_cfg // RULE_01
        |=> PROGRAM_TEST_MIRROR_O) else $error("programmed flag not set");

    c_start_ok:  cover property (CIPHER_START_I && !key_fail_q ##1 go_q);
    c_prog_cfg:  cover property (prog_cfg);
    c_lock_used: cover property (src_lock && !key_err && !src_sw);
    c_aes_otp:   cover property (CIPHER_SELECT_I && !key_err && !src_sw);
endmodule

// *** dv/test_cipher_key_source_config.sv ***
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("MISMATCH %s exp=%0h got=%0h", nm, (e), (g)); \
    end \
end

module test_cipher_key_source_config;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] cfg;
        logic        aes;
        logic [1:0]  md;
        logic [3:0]  src;
        logic [3:0]  eff;
        logic        fl;
    } row_t;

    // Software key slices use nibbles a..d so they never alias a stored page.
    localparam logic [255:0] sw_key = {{16{4'hd}}, {16{4'hc}},
                                       {16{4'hb}}, {16{4'ha}}};

    logic         ref_clk;
    logic         srst;
    logic         cipher_sel;
    logic [1:0]   key_mode;
    logic [3:0]   key_src;
    logic         cipher_start;
    logic [31:0]  cfg_image;
    logic [511:0] key_image;
    logic         prog_start;
    logic [3:0]   prog_page;
    logic [63:0]  prog_data;
    logic         key_fail;
    logic         cipher_go;
    logic [63:0]  pass1_key;
    logic [63:0]  pass2_key;
    logic [63:0]  pass3_key;
    logic [255:0] aes_key;
    logic [31:0]  cfg_page;
    logic         prog_mirror;
    logic         prog_done;
    logic         prog_fail;
    logic         load_busy;
    logic [511:0] ek;
    logic [31:0]  cur_cfg;
    int           error_cnt;
    int           tests_run;

    row_t rows [$] = '{
        '{32'ha000_0000, 1'h0, 2'h0, 4'h0, 4'h0, 1'h0},
        '{32'ha000_0000, 1'h0, 2'h0, 4'h1, 4'h1, 1'h0},
        '{32'ha000_0000, 1'h0, 2'h0, 4'h7, 4'h7, 1'h0},
        '{32'ha000_0000, 1'h0, 2'h0, 4'h8, 4'h8, 1'h1},
        '{32'ha000_0000, 1'h0, 2'h0, 4'hf, 4'hf, 1'h1},
        '{32'ha000_0000, 1'h0, 2'h1, 4'h4, 4'h4, 1'h0},
        '{32'ha000_0000, 1'h0, 2'h1, 4'h5, 4'h5, 1'h1},
        '{32'ha000_0000, 1'h0, 2'h2, 4'h0, 4'h0, 1'h1},
        '{32'ha000_0000, 1'h0, 2'h3, 4'h1, 4'h1, 1'h1},
        '{32'ha000_0000, 1'h1, 2'h0, 4'h0, 4'h0, 1'h0},
        '{32'ha000_0000, 1'h1, 2'h1, 4'h0, 4'h0, 1'h0},
        '{32'ha000_0000, 1'h1, 2'h2, 4'h0, 4'h0, 1'h0},
        '{32'ha000_0000, 1'h1, 2'h3, 4'h0, 4'h0, 1'h1},
        '{32'ha000_0000, 1'h1, 2'h0, 4'h1, 4'h1, 1'h1},
        '{32'h0150_0000, 1'h0, 2'h3, 4'h1, 4'h1, 1'h0},
        '{32'h0150_0000, 1'h0, 2'h3, 4'h2, 4'h2, 1'h0},
        '{32'h0150_0000, 1'h0, 2'h3, 4'h3, 4'h3, 1'h1},
        '{32'h0150_0000, 1'h0, 2'h3, 4'h0, 4'h0, 1'h0},
        '{32'h0150_0000, 1'h0, 2'h0, 4'h1, 4'h1, 1'h1},
        '{32'h0aa0_0000, 1'h1, 2'h0, 4'h4, 4'h4, 1'h0},
        '{32'h0aa0_0000, 1'h1, 2'h0, 4'h1, 4'h1, 1'h0},
        '{32'h0aa0_0000, 1'h1, 2'h0, 4'h5, 4'h5, 1'h1},
        '{32'h4ff0_0000, 1'h1, 2'h1, 4'h2, 4'h2, 1'h0},
        '{32'h4ff0_0000, 1'h1, 2'h2, 4'h2, 4'h2, 1'h0},
        '{32'h4ff0_0000, 1'h1, 2'h1, 4'h3, 4'h3, 1'h1},
        '{32'h0008_0001, 1'h0, 2'h0, 4'h0, 4'h0, 1'h1},
        '{32'h0008_0001, 1'h0, 2'h0, 4'h1, 4'h1, 1'h1},
        '{32'h0000_2400, 1'h0, 2'h0, 4'h0, 4'h3, 1'h0},
        '{32'h0004_0400, 1'h0, 2'h0, 4'h1, 4'hf, 1'h1},
        '{32'h0000_0400, 1'h0, 2'h0, 4'h8, 4'h0, 1'h0},
        '{32'h0004_0000, 1'h0, 2'h0, 4'h1, 4'h1, 1'h0}
    };

    cipher_key_source_config uut (
        .REF_CLK_I               (ref_clk),
        .SRST_I                  (srst),
        .CIPHER_SELECT_I         (cipher_sel),
        .KEY_MODE_FIELD_I        (key_mode),
        .KEY_SOURCE_CODE_I       (key_src),
        .SOFTWARE_KEY_REGISTER_I (sw_key),
        .CIPHER_START_I          (cipher_start),
        .OTP_CFG_IMAGE_I         (cfg_image),
        .OTP_KEY_IMAGE_I         (key_image),
        .OTP_PROGRAM_START_I     (prog_start),
        .OTP_PAGE_SELECT_I       (prog_page),
        .THIRD_TEXT_BUFFER_I     (prog_data),
        .KEY_FAILURE_FLAG_O      (key_fail),
        .CIPHER_GO_O             (cipher_go),
        .PASS1_KEY_O             (pass1_key),
        .PASS2_KEY_O             (pass2_key),
        .PASS3_KEY_O             (pass3_key),
        .AES_KEY_O               (aes_key),
        .SECURE_KEY_CONFIG_PAGE_O(cfg_page),
        .PROGRAM_TEST_MIRROR_O   (prog_mirror),
        .PROGRAM_DONE_O          (prog_done),
        .PROGRAM_FAIL_O          (prog_fail),
        .OTP_LOAD_BUSY_O         (load_busy)
    );

    always #5 ref_clk = ~ref_clk;

    function automatic logic [63:0] pg(input logic [3:0] i);
        return {16{i}};
    endfunction

    // Slice count per mode: DES 1/2/-/3 pages, AES 2/3/4 pages.
    function automatic logic [511:0] exp_keys(input row_t r);
        logic [63:0]  sl [4];
        logic [255:0] ak;
        int           n;
        n = r.aes ? int'(r.md) + 2 : (r.md == 2'h3 ? 3 : int'(r.md) + 1);
        ak = '0;
        for (int k = 0; k < 4; k++) begin
            sl[k] = (r.eff == 4'h0) ? sw_key[64*k +: 64]
                  : pg(4'((int'(r.eff) - 1) * n + 1 + k));
            if (k < n) ak[64*k +: 64] = sl[k];
        end
        if (r.fl) return '0;
        if (r.aes) return {ak, 256'h0};
        return {256'h0, 64'h0, (n > 2) ? sl[2] : sl[0],
                (n > 1) ? sl[1] : sl[0], sl[0]};
    endfunction

    task automatic tally_and_finish;
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_reset(input logic [31:0] c);
        @(posedge ref_clk);
        srst <= 1'b1;
        cfg_image <= c;
        repeat (12) @(posedge ref_clk);
        #1;
        `CHK("fail_in_reset", 1'b1, key_fail)
        `CHK("busy_in_reset", 1'b1, load_busy)
        @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("busy_after", 1'b0, load_busy)
        `CHK("cfg_page", c & cipher_key_pkg::CFG_READ_MASK, cfg_page)
        `CHK("mirror", c[30], prog_mirror)
    endtask

    task automatic apply(input logic a, input logic [1:0] m,
                         input logic [3:0] s);
        @(posedge ref_clk);
        cipher_sel <= a;
        key_mode <= m;
        key_src <= s;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic otp_write(input logic [3:0] p, input logic [63:0] d,
                             input logic ok);
        @(posedge ref_clk);
        prog_start <= 1'b1;
        prog_page <= p;
        prog_data <= d;
        @(posedge ref_clk);
        prog_start <= 1'b0;
        #1;
        `CHK("prog_done", ok, prog_done)
        `CHK("prog_fail", ~ok, prog_fail)
    endtask

    // Start is held two cycles so back-to-back acceptance is exercised.
    task automatic start_check(input logic e);
        @(posedge ref_clk);
        cipher_start <= 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK("go_first", e, cipher_go)
        @(posedge ref_clk);
        cipher_start <= 1'b0;
        #1;
        `CHK("go_second", e, cipher_go)
        @(posedge ref_clk);
        #1;
        `CHK("go_idle", 1'b0, cipher_go)
    endtask

    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        ref_clk = 1'b0;
        srst = 1'b1;
        cipher_sel = 1'b0;
        key_mode = 2'h0;
        key_src = 4'h0;
        cipher_start = 1'b0;
        cfg_image = 32'h0000_0000;
        prog_start = 1'b0;
        prog_page = 4'h0;
        prog_data = 64'h0;
        error_cnt = 0;
        tests_run = 0;
        cur_cfg = 32'hffff_ffff;
        for (int k = 1; k <= 8; k++) key_image[64*(k-1) +: 64] = pg(4'(k));
        foreach (rows[i]) begin
            if (rows[i].cfg !== cur_cfg) begin
                do_reset(rows[i].cfg);
                cur_cfg = rows[i].cfg;
            end
            apply(rows[i].aes, rows[i].md, rows[i].src);
            ek = exp_keys(rows[i]);
            `CHK("key_fail", rows[i].fl, key_fail)
            `CHK("pass1", ek[63:0], pass1_key)
            `CHK("pass2", ek[127:64], pass2_key)
            `CHK("pass3", ek[191:128], pass3_key)
            `CHK("aes_key", ek[511:256], aes_key)
        end
        do_reset(32'h0000_0010);
        apply(1'b0, 2'h0, 4'h1);
        otp_write(4'h3, 64'h0f, 1'b0);
        otp_write(4'h2, 64'hf0, 1'b1);
        apply(1'b0, 2'h0, 4'h2);
        `CHK("prog_or", pg(4'h2) | 64'hf0, pass1_key)
        otp_write(4'h9, 64'h0, 1'b0);
        apply(1'b1, 2'h3, 4'h0);
        otp_write(4'h1, 64'h1, 1'b0);
        apply(1'b0, 2'h0, 4'h1);
        otp_write(4'h0, 64'h3000_0001, 1'b1);
        `CHK("cfg_prog", 32'h4000_0011, cfg_page)
        `CHK("mirror_prog", 1'b1, prog_mirror)
        apply(1'b0, 2'h0, 4'h0);
        `CHK("swdis_fail", 1'b1, key_fail)
        start_check(1'b0);
        apply(1'b0, 2'h0, 4'h1);
        `CHK("fail_clears", 1'b0, key_fail)
        start_check(1'b1);
        otp_write(4'h0, 64'h0, 1'b1);
        `CHK("cfg_sticky", 32'h4000_0011, cfg_page)
        otp_write(4'h0, 64'h2, 1'b1);
        otp_write(4'h0, 64'h4, 1'b0);
        do_reset(32'h0000_0010);
        tally_and_finish();
    end
endmodule
